/* rtl/rmfd_pkg.sv */
package rmfd_pkg;
  // Boot memory word addresses used during the reset sequence.
  localparam logic [31:0] MODE_VEC_ADDR = 32'h000ffff8;
  localparam logic [31:0] RESET_VEC_ADDR = 32'h000ffffc;
  // Vector table defaults and the debug tool NMI entry.
  localparam logic [31:0] TABLE_BASE_RESET = 32'h000ffc00;
  localparam logic [9:0] DBG_NMI_OFFSET = 10'h3c8;
  localparam logic [7:0] DBG_NMI_NUMBER = 8'h0d;
  localparam logic [31:0] BREAK_FACTOR_ADDR = 32'h00000b00;
  // Direct addressing window limits per access width.
  localparam logic [31:0] DIRECT_LIMIT_BYTE = 32'h000000ff;
  localparam logic [31:0] DIRECT_LIMIT_HALF = 32'h000001ff;
  localparam logic [31:0] DIRECT_LIMIT_WORD = 32'h000003ff;
  // Mode strap codes and the expected reserved mode byte.
  localparam logic [2:0] STRAP_INTERNAL = 3'h0;
  localparam logic [2:0] STRAP_EXTERNAL = 3'h1;
  // Edges the strap synchronisers need after reset release before their output is the pin level.
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  localparam logic [7:0] MODE_BYTE_EXPECTED = 8'h07;
  localparam int MODE_BYTE_MSB = 31;
  localparam int MODE_BYTE_LSB = 24;
  // Access width codes.
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  typedef enum logic [2:0] {
    RMFD_SYNC = 3'b000,
    RMFD_MODE_REQ = 3'b001,
    RMFD_VEC_REQ = 3'b010,
    RMFD_RUN = 3'b011,
    RMFD_FAULT = 3'b100
  } rmfd_state_t;
endpackage : rmfd_pkg

/* rtl/rmfd_sync2.sv */
`timescale 1ns/100ps
module rmfd_sync2 (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic din, // Asynchronous level.
  output logic dout // Synchronised level.
);
  logic stage1;

  // Two flops; only the second stage is visible to logic.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule : rmfd_sync2

/* rtl/rmfd_boot.sv */
`timescale 1ns/100ps
module rmfd_boot (
  input wire logic clk_sys, // System clock, 10 MHz.
  input wire logic rstn, // Any reset source, asynchronous, active low.
  input wire logic modeStrapBit0, // Mode strap pin 0.
  input wire logic modeStrapBit1, // Mode strap pin 1.
  input wire logic modeStrapBit2, // Mode strap pin 2.
  output logic bootReq, // Boot memory read request.
  output logic [31:0] bootAddr, // Boot memory word address.
  output logic bootExternal, // Request targets external memory.
  input wire logic bootAck, // Boot memory answer strobe.
  input wire logic [31:0] bootData, // Boot memory read word.
  output logic [7:0] bootModeRegister, // Loaded mode byte.
  output logic [31:0] resetVector, // Fetched reset vector.
  output logic cpuStart, // CPU may execute the first instruction.
  output logic strapFault, // Unsupported strap setting was seen.
  output logic modeByteBad, // Mode byte differs from the expected value.
  input wire logic [31:0] vectorTableBase, // Current table base register.
  output logic [31:0] debugNmiVectorAddr, // Debug NMI vector address.
  output logic [7:0] debugNmiNumber, // Debug NMI interrupt number.
  input wire logic debugBreakReq, // Emulator break request from debug_support_pin.
  input wire logic emulatorAttached, // Emulator present.
  input wire logic dataWrite, // CPU data write strobe.
  input wire logic [31:0] dataAddr, // CPU data address.
  input wire logic [7:0] dataWdata, // CPU write byte.
  output logic breakFactor, // Break factor flag.
  output logic debugNmiReq, // Debug NMI request level.
  input wire logic [31:0] directAddr, // Operand address of a direct access.
  input wire logic [1:0] directSize, // Access width code.
  output logic directHit // Address lies inside the direct window.
);
  logic [2:0] strapSync;
  logic breakSync;
  logic [2:0] strapLatched;
  rmfd_pkg::rmfd_state_t state;
  rmfd_pkg::rmfd_state_t next_state;
  logic breakWrite;
  logic [1:0] settleCount;

  // Straps are pins, so each goes through a two-flop synchroniser.
  rmfd_sync2 uSync0 (.clk_sys(clk_sys), .rstn(rstn), .din(modeStrapBit0), .dout(strapSync[0]));
  rmfd_sync2 uSync1 (.clk_sys(clk_sys), .rstn(rstn), .din(modeStrapBit1), .dout(strapSync[1]));
  rmfd_sync2 uSync2 (.clk_sys(clk_sys), .rstn(rstn), .din(modeStrapBit2), .dout(strapSync[2]));
  rmfd_sync2 uSyncB (.clk_sys(clk_sys), .rstn(rstn), .din(debugBreakReq), .dout(breakSync));

  // Synchronisers leave reset at zero, so the sequencer waits until the pin level has reached their outputs.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      settleCount <= 2'h0;
    end else if (state == rmfd_pkg::RMFD_SYNC && settleCount != rmfd_pkg::SETTLE_CYCLES) begin
      settleCount <= settleCount + 2'h1;
    end
  end

  // Boot sequencer; the wait state lets the synchronisers settle before straps are caught.
  always_comb begin
    next_state = state;
    case (state)
      rmfd_pkg::RMFD_SYNC: begin
        if (settleCount == rmfd_pkg::SETTLE_CYCLES) begin
          next_state = rmfd_pkg::RMFD_MODE_REQ;
        end
      end
      rmfd_pkg::RMFD_MODE_REQ: begin
        if (strapLatched != rmfd_pkg::STRAP_INTERNAL) begin
          next_state = rmfd_pkg::RMFD_FAULT;
        end else if (bootAck) begin
          next_state = rmfd_pkg::RMFD_VEC_REQ;
        end
      end
      rmfd_pkg::RMFD_VEC_REQ: begin
        if (bootAck) begin
          next_state = rmfd_pkg::RMFD_RUN;
        end
      end
      rmfd_pkg::RMFD_RUN: begin
        next_state = rmfd_pkg::RMFD_RUN;
      end
      rmfd_pkg::RMFD_FAULT: begin
        next_state = rmfd_pkg::RMFD_FAULT;
      end
      default: begin
        next_state = rmfd_pkg::RMFD_FAULT;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= rmfd_pkg::RMFD_SYNC;
    end else begin
      state <= next_state;
    end
  end

  // Straps are loaded on every RMFD_SYNC cycle and held after it, so later noise cannot change the boot path.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      strapLatched <= rmfd_pkg::STRAP_INTERNAL;
    end else if (state == rmfd_pkg::RMFD_SYNC) begin
      strapLatched <= strapSync;
    end
  end

  // Fetch requests; only the internal area is ever addressed.
  always_comb begin
    bootReq = (state == rmfd_pkg::RMFD_MODE_REQ && strapLatched == rmfd_pkg::STRAP_INTERNAL)
      || state == rmfd_pkg::RMFD_VEC_REQ;
    bootAddr = (state == rmfd_pkg::RMFD_VEC_REQ) ? rmfd_pkg::RESET_VEC_ADDR : rmfd_pkg::MODE_VEC_ADDR;
    bootExternal = 1'b0;
    cpuStart = (state == rmfd_pkg::RMFD_RUN);
    strapFault = (state == rmfd_pkg::RMFD_FAULT);
  end

  // Mode register is loaded only by the boot fetch; no write port exists for software.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bootModeRegister <= 8'h00;
      modeByteBad <= 1'b0;
    end else if (state == rmfd_pkg::RMFD_MODE_REQ && bootAck) begin
      bootModeRegister <= bootData[rmfd_pkg::MODE_BYTE_MSB:rmfd_pkg::MODE_BYTE_LSB];
      modeByteBad <= bootData[rmfd_pkg::MODE_BYTE_MSB:rmfd_pkg::MODE_BYTE_LSB]
        != rmfd_pkg::MODE_BYTE_EXPECTED;
    end
  end

  // Reset vector capture.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      resetVector <= 32'h00000000;
    end else if (state == rmfd_pkg::RMFD_VEC_REQ && bootAck) begin
      resetVector <= bootData;
    end
  end

  // Debug NMI vector; the 32-bit sum wraps across the full address space.
  always_comb begin
    debugNmiVectorAddr = vectorTableBase + {22'h000000, rmfd_pkg::DBG_NMI_OFFSET};
    debugNmiNumber = rmfd_pkg::DBG_NMI_NUMBER;
    debugNmiReq = breakFactor;
  end

  // Break factor: set by a break even when noise fakes one; a set beats a clear in the same cycle.
  assign breakWrite = dataWrite && dataAddr == rmfd_pkg::BREAK_FACTOR_ADDR && dataWdata == 8'h00;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      breakFactor <= 1'b0;
    end else if (breakSync) begin
      breakFactor <= 1'b1;
    end else if (breakWrite) begin
      breakFactor <= 1'b0;
    end
  end

  // Direct addressing window decode.
  always_comb begin
    case (directSize)
      rmfd_pkg::SIZE_BYTE: directHit = directAddr <= rmfd_pkg::DIRECT_LIMIT_BYTE;
      rmfd_pkg::SIZE_HALF: directHit = directAddr <= rmfd_pkg::DIRECT_LIMIT_HALF;
      rmfd_pkg::SIZE_WORD: directHit = directAddr <= rmfd_pkg::DIRECT_LIMIT_WORD;
      default: directHit = 1'b0;
    endcase
  end

  // Mode load precedes the vector fetch, and the CPU starts only after both.
  property p_order;
    @(posedge clk_sys) disable iff (!rstn)
    (state == rmfd_pkg::RMFD_MODE_REQ && bootAck && strapLatched == rmfd_pkg::STRAP_INTERNAL)
      |=> bootReq && bootAddr == rmfd_pkg::RESET_VEC_ADDR && !cpuStart;
  endproperty
  a_order: assert property (p_order) else $error("Vector fetch did not follow mode load.");

  property p_modeLoad;
    @(posedge clk_sys) disable iff (!rstn)
    (state == rmfd_pkg::RMFD_MODE_REQ && bootAck && strapLatched == rmfd_pkg::STRAP_INTERNAL)
      |=> bootModeRegister == $past(bootData[31:24]);
  endproperty
  a_modeLoad: assert property (p_modeLoad) else $error("Mode byte not taken from top byte.");

  property p_modeHold;
    @(posedge clk_sys) disable iff (!rstn)
    (state == rmfd_pkg::RMFD_RUN) |=> $stable(bootModeRegister);
  endproperty
  a_modeHold: assert property (p_modeHold) else $error("Mode register changed after boot.");

  property p_strapFault;
    @(posedge clk_sys) disable iff (!rstn)
    (state == rmfd_pkg::RMFD_MODE_REQ && strapLatched != rmfd_pkg::STRAP_INTERNAL) |=> strapFault[*3];
  endproperty
  a_strapFault: assert property (p_strapFault) else $error("Bad strap did not stop the boot.");

  property p_internal;
    @(posedge clk_sys) disable iff (!rstn)
    bootReq |-> !bootExternal && (bootAddr == rmfd_pkg::MODE_VEC_ADDR || bootAddr == rmfd_pkg::RESET_VEC_ADDR);
  endproperty
  a_internal: assert property (p_internal) else $error("Fetch left the internal area.");

  property p_nmiVec;
    @(posedge clk_sys) disable iff (!rstn)
    (vectorTableBase == rmfd_pkg::TABLE_BASE_RESET) |-> debugNmiVectorAddr == 32'h000fffc8;
  endproperty
  a_nmiVec: assert property (p_nmiVec) else $error("Debug NMI vector address wrong.");

  property p_breakSet;
    @(posedge clk_sys) disable iff (!rstn)
    $rose(breakFactor) |-> $past(breakSync);
  endproperty
  a_breakSet: assert property (p_breakSet) else $error("Break factor set without a break.");

  property p_breakClr;
    @(posedge clk_sys) disable iff (!rstn)
    (breakWrite && !breakSync) |=> !breakFactor ##0 !debugNmiReq;
  endproperty
  a_breakClr: assert property (p_breakClr) else $error("Break factor not cleared.");

  property p_window;
    @(posedge clk_sys) disable iff (!rstn)
    (directSize == rmfd_pkg::SIZE_HALF) |-> directHit == (directAddr < 32'h00000200);
  endproperty
  a_window: assert property (p_window) else $error("Halfword window decode wrong.");
endmodule : rmfd_boot

/* dv/rmfd_boot_mem.sv */
`timescale 1ns/100ps
module rmfd_boot_mem (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Reset, active low.
  input wire logic bootReq, // Fetch request.
  input wire logic [31:0] bootAddr, // Fetch word address.
  input wire logic [3:0] waitCycles, // Answer delay in cycles.
  input wire logic [7:0] modeByte, // Stored mode byte.
  input wire logic [31:0] vecWord, // Stored reset vector.
  output logic bootAck, // Answer strobe.
  output logic [31:0] bootData // Read word.
);
  logic [3:0] waitCount;
  // Answer each request once after the wait; between answers the bus churns so a stale word never matches.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      waitCount <= 4'h0;
      bootAck <= 1'b0;
      bootData <= 32'hc3c3c3c3;
    end else if (bootReq && !bootAck && waitCount >= waitCycles) begin
      waitCount <= 4'h0;
      bootAck <= 1'b1;
      if (bootAddr == rmfd_pkg::MODE_VEC_ADDR) begin
        bootData <= {modeByte, 24'h5a96e1}; // Mode byte in the top lane.
      end else begin
        bootData <= vecWord;
      end
    end else begin
      waitCount <= (bootReq && !bootAck) ? waitCount + 4'h1 : 4'h0;
      bootAck <= 1'b0;
      bootData <= ~bootData;
    end
  end
endmodule : rmfd_boot_mem

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic clk_sys = 0, rstn = 0, bootAck, bootReq, bootExternal, cpuStart, strapFault, modeByteBad;
  logic s0 = 0, s1 = 0, s2 = 0, brk = 0, emu = 0, dataWrite = 0, directHit, breakFactor, debugNmiReq;
  logic [31:0] bootAddr, bootData, resetVector, dbgAddr, dataAddr = 0, directAddr = 0, vecWord = 0;
  logic [31:0] tblBase = 32'h000ffc00;
  logic [7:0] modeReg, dbgNum, dataWdata = 0, modeByte = 0;
  logic [3:0] waitCycles = 0;
  logic [1:0] directSize = 0;
  int errTotal = 0, cmpCount = 0;
  // Direct window rows: address, width code, expected hit.
  logic [34:0] rows [9] = '{{32'h000000ff, 2'h0, 1'b1}, {32'h00000100, 2'h0, 1'b0}, {32'h000001ff, 2'h1, 1'b1},
    {32'h00000200, 2'h1, 1'b0}, {32'h000003ff, 2'h2, 1'b1}, {32'h00000400, 2'h2, 1'b0},
    {32'h00000000, 2'h2, 1'b1}, {32'h100000ff, 2'h0, 1'b0}, {32'h00000000, 2'h3, 1'b0}};
  rmfd_boot rmfd_boot_inst (.clk_sys(clk_sys), .rstn(rstn), .modeStrapBit0(s0), .modeStrapBit1(s1),
    .modeStrapBit2(s2), .bootReq(bootReq), .bootAddr(bootAddr), .bootExternal(bootExternal), .bootAck(bootAck),
    .bootData(bootData), .bootModeRegister(modeReg), .resetVector(resetVector), .cpuStart(cpuStart),
    .strapFault(strapFault), .modeByteBad(modeByteBad), .vectorTableBase(tblBase), .debugNmiVectorAddr(dbgAddr),
    .debugNmiNumber(dbgNum), .debugBreakReq(brk), .emulatorAttached(emu), .dataWrite(dataWrite),
    .dataAddr(dataAddr), .dataWdata(dataWdata), .breakFactor(breakFactor), .debugNmiReq(debugNmiReq),
    .directAddr(directAddr), .directSize(directSize), .directHit(directHit));
  rmfd_boot_mem rmfd_boot_mem_inst (.clk_sys(clk_sys), .rstn(rstn), .bootReq(bootReq), .bootAddr(bootAddr),
    .waitCycles(waitCycles), .modeByte(modeByte), .vecWord(vecWord), .bootAck(bootAck), .bootData(bootData));
  // Free-running 10 MHz clock.
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("errors=%0d compares=%0d", errTotal, cmpCount);
    if (errTotal == 0 && cmpCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  // Reset with the given straps, then collect the fetch addresses in the order they are answered.
  task automatic boot(input logic [2:0] straps, input logic [3:0] dly, input logic [7:0] mb);
    int acks;
    logic [31:0] seen [2];
    acks = 0;
    @(posedge clk_sys);
    rstn <= 1'b0;
    {s2, s1, s0} <= straps;
    waitCycles <= dly;
    modeByte <= mb;
    vecWord <= 32'h00012340 + 32'(dly);
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int n = 0; n < 100 && cpuStart !== 1'b1; n++) begin
      @(negedge clk_sys);
      if (bootAck === 1'b1 && bootReq === 1'b1 && acks < 2) begin
        seen[acks] = bootAddr;
        acks++;
      end
    end
    @(negedge clk_sys);
    if (straps == 3'h0) begin
      check(32'(acks), 32'h2);
      check(seen[0], 32'h000ffff8);
      check(seen[1], 32'h000ffffc);
      check(resetVector, 32'h00012340 + 32'(dly));
      check({24'h0, modeReg}, {24'h0, mb});
      check({31'h0, modeByteBad}, {31'h0, mb != 8'h07});
      check({30'h0, strapFault, bootExternal}, 32'h0);
    end else begin
      check(32'(acks), 32'h0);
      check({30'h0, strapFault, cpuStart}, 32'h2);
    end
  endtask : boot
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    dataWrite <= 1'b1;
    dataAddr <= a;
    dataWdata <= d;
    @(posedge clk_sys);
    dataWrite <= 1'b0;
    @(negedge clk_sys);
  endtask : wr
  // Stop a hung run well past the expected few hundred cycles.
  initial begin
    #(100 * 20000);
    errTotal++;
    finish_test();
  end
  // Main sequence: direct window rows, boots, debug vector and break flag.
  initial begin
    boot(3'h0, 4'h0, 8'h07);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      {directAddr, directSize} <= rows[i][34:1];
      @(negedge clk_sys);
      check({31'h0, directHit}, {31'h0, rows[i][0]});
    end
    boot(3'h0, 4'h5, 8'h3c);
    boot(3'h0, 4'h2, 8'h07);
    boot(3'h1, 4'h0, 8'h07);
    boot(3'h6, 4'h0, 8'h07);
    boot(3'h0, 4'h1, 8'h07);
    check(dbgAddr, 32'h000fffc8);
    check({24'h0, dbgNum}, 32'h0000000d);
    @(posedge clk_sys);
    tblBase <= 32'h00010000;
    @(negedge clk_sys);
    check(dbgAddr, 32'h000103c8);
    check({30'h0, breakFactor, debugNmiReq}, 32'h0);
    @(posedge clk_sys);
    brk <= 1'b1;
    repeat (2) @(posedge clk_sys);
    brk <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check({30'h0, breakFactor, debugNmiReq}, 32'h3);
    @(posedge clk_sys);
    emu <= 1'b1;
    wr(32'h00000b00, 8'h01);
    wr(32'h00000b04, 8'h00);
    check({31'h0, breakFactor}, 32'h1);
    wr(32'h00000b00, 8'h00);
    check({30'h0, breakFactor, debugNmiReq}, 32'h0);
    check({24'h0, modeReg}, 32'h00000007);
    finish_test();
  end
endmodule : testbench
